/* File: verilog/rsmc_defs.svh */
// rsmc_defs.svh: offsets, field positions, codes, widths and timing counts of the strap block
`ifndef RSMC_DEFS_SVH
`define RSMC_DEFS_SVH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define RSMC_CLK_PERIOD_NS 40
`define RSMC_T_PARTIAL_NS 100
`define RSMC_T_FULL_NS 1200
`define RSMC_T_CONV_NS 800
// least times: round up to whole cycles
`define RSMC_PARTIAL_CYC ((`RSMC_T_PARTIAL_NS + `RSMC_CLK_PERIOD_NS - 1) / `RSMC_CLK_PERIOD_NS)
`define RSMC_FULL_CYC ((`RSMC_T_FULL_NS + `RSMC_CLK_PERIOD_NS - 1) / `RSMC_CLK_PERIOD_NS)
`define RSMC_CONV_CYC ((`RSMC_T_CONV_NS + `RSMC_CLK_PERIOD_NS - 1) / `RSMC_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------------
`define RSMC_ADR_CFG 8'h00
`define RSMC_ADR_STRAP 8'h04
`define RSMC_ADR_STATUS 8'h08
`define RSMC_ADR_RESULT 8'h0c
`define RSMC_CFG_BURST_BIT 0
`define RSMC_CFG_LAST_LSB 4
`define RSMC_CFG_LAST_MSB 6

// ----------------------------------------------------------------------------
// codes and widths
// ----------------------------------------------------------------------------
`define RSMC_RANGE_SW 2'h0
`define RSMC_RESULT_W 16
`define RSMC_CNT_W 16

`endif

/* File: verilog/rsmc_pkg.sv */
// rsmc_pkg.sv: types of the reset, strap and mode control block
package rsmc_pkg;

    // ------------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------------
    // interface family as latched from the straps
    typedef enum logic [1:0] {
        RSMC_IF_PAR = 2'h0,
        RSMC_IF_BYTE = 2'h1,
        RSMC_IF_SER = 2'h3
    } rsmc_iface_e;

    // reset pin meter: running or pin held low
    typedef enum logic {
        RSMC_MT_RUN = 1'h0,
        RSMC_MT_LOW = 1'h1
    } rsmc_meter_e;

    // ------------------------------------------------------------------------
    // state records
    // ------------------------------------------------------------------------
    typedef struct packed {
        rsmc_meter_e st;
        logic [15:0] cnt;
        logic inr;
        logic rel;
        logic part;
        logic full;
    } rsmc_meter_s;

    typedef struct packed {
        logic busy;
        logic [15:0] cnt;
        logic conv_prev;
        logic reference_source_strap;
        logic refbuf;
        logic [1:0] range;
        logic hw;
        logic seq_on;
        rsmc_iface_e iface;
        logic burst;
        logic [2:0] seq_last;
        logic [2:0] seq_chan;
        logic [3:0] prog_nib;
        logic [15:0] res_a;
        logic [15:0] res_b;
        logic invalid;
        logic last_full;
        logic ack;
        logic [31:0] rdat;
        logic oe;
        logic [3:0] dout;
    } rsmc_top_s;

endpackage : rsmc_pkg

/* File: verilog/rsmc_rst_meter.sv */
// rsmc_rst_meter.sv: measures the low time of the device reset pin and names the reset kind
`include "rsmc_defs.svh"

module rsmc_rst_meter
    import rsmc_pkg::*;
#(
    parameter int unsigned PARTIAL_CYC = `RSMC_PARTIAL_CYC,
    parameter int unsigned FULL_CYC = `RSMC_FULL_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic dev_reset_n_i,
    output logic in_reset_o,
    output logic release_o,
    output logic partial_o,
    output logic full_o
);

    // thresholds at counter width
    localparam logic [15:0] PART_C = 16'(PARTIAL_CYC);
    localparam logic [15:0] FULL_C = 16'(FULL_CYC);

    rsmc_meter_s q; // registered state
    rsmc_meter_s d; // next state

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        d = q;
        d.rel = 1'b0;
        d.part = 1'b0;
        d.full = 1'b0;
        unique case (q.st)
            RSMC_MT_RUN: begin
                // any low sample enters reset at the next clock edge, busy or not
                if (!dev_reset_n_i) begin // see [R04]
                    d.st = RSMC_MT_LOW;
                    d.cnt = 16'h0001;
                    d.inr = 1'b1;
                end
            end
            RSMC_MT_LOW: begin
                if (dev_reset_n_i) begin
                    // pulse length decides the kind; short glitches name none
                    d.st = RSMC_MT_RUN;
                    d.inr = 1'b0;
                    d.rel = (q.cnt >= PART_C); // see [R05]
                    d.full = (q.cnt >= FULL_C); // see [R06]
                    d.part = (q.cnt >= PART_C) && (q.cnt < FULL_C); // see [R06]
                end else if (q.cnt < FULL_C) begin
                    // saturate: anything longer is still a full reset
                    d.cnt = q.cnt + 16'h0001;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign in_reset_o = q.inr;
    assign release_o = q.rel;
    assign partial_o = q.part;
    assign full_o = q.full;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_ENTER_RESET: assert property ($fell(dev_reset_n_i) |=> in_reset_o) // see [R04]
        else $error("reset pin low not seen as reset");
    AST_FULL_KIND: assert property (full_o |-> $past(q.cnt) >= FULL_C && !partial_o) // see [R06]
        else $error("full reset named on a short pulse");
    AST_PARTIAL_KIND: assert property ( // see [R05]
        partial_o |-> $past(q.cnt) >= PART_C && $past(q.cnt) < FULL_C)
        else $error("partial reset named on a wrong pulse length");

endmodule : rsmc_rst_meter

/* File: verilog/rsmc_top.sv */
// rsmc_top.sv: reset decode, strap latching, mode and pin role control with a wishbone slave
//
// Implementation choices: the register addresses and register access over Wishbone.
`include "rsmc_defs.svh"

// Contract
// [R01] reference strap caught at reset rise only
// [R02] strap high: band-gap on; low: external
// [R03] reference buffer always enabled
// [R04] reset pin low, asynchronous, forces reset; code samples it on the clock, one cycle late
// [R05] low pulse length selects partial or full
// [R06] thresholds are parameters; long pulse is full
// [R07] partial reset keeps programmed and latched values
// [R08] full reset restores defaults, relatches straps
// [R09] reset during conversion aborts, result invalid
// [R10] reset during read clears output data
// [R11] host resets after power-up and shutdown
// [R12] host waits after reset before conversion start
// [R13] hardware sequencer enabled by strap, steps
// [R14] range strap 00 software, else hardware range
// [R15] family strap: low parallel, high serial/byte
// [R16] byte/serial strap latched: high byte, low serial
// [R17] software parallel/byte: low pins bidirectional
// [R18] hardware parallel/byte: low pins output only
// [R19] serial mode: host grounds low pins
// [R20] results are 16-bit twos complement codes
module rsmc_top
    import rsmc_pkg::*;
#(
    parameter int unsigned PARTIAL_CYC = `RSMC_PARTIAL_CYC,
    parameter int unsigned FULL_CYC = `RSMC_FULL_CYC,
    parameter int unsigned CONV_CYC = `RSMC_CONV_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // host side pins
    input wire logic dev_reset_n_i,
    input wire logic conversion_start_pin_i,
    input wire logic reference_source_strap_i,
    input wire logic sequencer_enable_strap_i,
    input wire logic [1:0] range_mode_strap_i,
    input wire logic interface_family_strap_i,
    input wire logic byte_serial_select_strap_i,
    input wire logic host_read_i,
    input wire logic host_write_i,
    input wire logic [3:0] low_data_pins_i,
    output logic [3:0] low_data_pins_o,
    output logic low_data_pins_oe_o,
    // converter core side
    input wire logic [15:0] adc_result_a_i,
    input wire logic [15:0] adc_result_b_i,
    output logic bandgap_en_o,
    output logic ref_buffer_en_o,
    output logic hw_mode_o,
    output logic [1:0] range_mode_o,
    output logic [1:0] interface_mode_o,
    output logic sequencer_on_o,
    output logic [2:0] seq_channel_o,
    output logic conv_busy_o,
    output logic result_invalid_o,
    output logic device_in_reset_o
);

    // ------------------------------------------------------------------------
    // constants and helpers
    // ------------------------------------------------------------------------
    localparam logic [15:0] CONV_LAST = 16'(CONV_CYC - 1); // last busy count

    // next sequencer channel, wrapping after the programmed last one
    function automatic logic [2:0] next_chan(input logic [2:0] chan, input logic [2:0] last);
        next_chan = (chan >= last) ? 3'h0 : chan + 3'h1;
    endfunction : next_chan

    rsmc_top_s q; // registered state
    rsmc_top_s d; // next state

    logic inr_w; // reset pin held low, one cycle late
    logic rel_w; // pulse: qualified reset released
    logic part_w; // pulse: partial reset released
    logic full_w; // pulse: full reset released
    logic req_w; // wishbone cycle in progress
    logic start_w; // rising edge of conversion start
    logic done_w; // last cycle of a conversion
    logic [2:0] chan_n; // channel after this conversion

    // ------------------------------------------------------------------------
    // reset pin meter
    // ------------------------------------------------------------------------
    rsmc_rst_meter #(
        .PARTIAL_CYC(PARTIAL_CYC),
        .FULL_CYC(FULL_CYC)
    ) u_meter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .dev_reset_n_i(dev_reset_n_i),
        .in_reset_o(inr_w),
        .release_o(rel_w),
        .partial_o(part_w),
        .full_o(full_w)
    );

    assign req_w = wb_cyc_i && wb_stb_i;
    // inputs are synchronous, so a single previous sample is enough
    assign start_w = conversion_start_pin_i && !q.conv_prev;
    assign done_w = q.busy && (q.cnt == CONV_LAST);
    assign chan_n = next_chan(q.seq_chan, q.seq_last);

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        d = q;
        d.ack = 1'b0;
        d.conv_prev = conversion_start_pin_i;
        d.refbuf = 1'b1; // buffer stays on in both reference modes; see [R03]

        // wishbone: answer one cycle after the request, drop ack after that
        if (req_w && !q.ack) begin
            d.ack = 1'b1;
            unique case (wb_adr_i)
                `RSMC_ADR_CFG: begin
                    d.rdat = {25'h0, q.seq_last, 3'h0, q.burst};
                end
                `RSMC_ADR_STRAP: begin
                    d.rdat = {25'h0, q.iface, q.seq_on, q.hw, q.range, q.reference_source_strap};
                end
                `RSMC_ADR_STATUS: begin
                    d.rdat = {20'h0, q.last_full, q.invalid, q.busy, inr_w,
                              1'h0, q.seq_chan, q.prog_nib};
                end
                `RSMC_ADR_RESULT: begin
                    d.rdat = {q.res_b, q.res_a}; // twos complement codes; see [R20]
                end
                default: begin
                    d.rdat = 32'h0; // unmapped reads as zero, still acked
                end
            endcase
        end
        // writes land on the edge where the master sees ack
        if (req_w && q.ack && wb_we_i && wb_adr_i == `RSMC_ADR_CFG && wb_sel_i[0]) begin
            d.burst = wb_dat_i[`RSMC_CFG_BURST_BIT];
            d.seq_last = wb_dat_i[`RSMC_CFG_LAST_MSB:`RSMC_CFG_LAST_LSB];
        end

        // reference strap is caught on every qualified release
        if (rel_w) begin
            d.reference_source_strap = reference_source_strap_i; // see [R01]
        end

        // partial reset: reinit internal state only; config kept
        if (part_w) begin
            d.seq_chan = 3'h0; // see [R07]
            d.last_full = 1'b0;
        end

        // full reset: defaults back, every strap caught again
        if (full_w) begin
            d.burst = 1'b0; // see [R08]
            d.seq_last = 3'h0;
            d.seq_chan = 3'h0;
            d.prog_nib = 4'h0;
            d.last_full = 1'b1;
            d.range = range_mode_strap_i; // see [R14]
            d.hw = (range_mode_strap_i != `RSMC_RANGE_SW); // see [R14]
            // sequencer only exists in hardware mode
            d.seq_on = sequencer_enable_strap_i && d.hw; // see [R13]
            if (!interface_family_strap_i) begin
                d.iface = RSMC_IF_PAR; // see [R15]
            end else if (byte_serial_select_strap_i) begin
                d.iface = RSMC_IF_BYTE; // see [R16]
            end else begin
                d.iface = RSMC_IF_SER; // see [R16]
            end
        end

        // conversion tracking
        if (inr_w) begin
            // reset wins over everything the converter was doing
            if (q.busy) begin
                d.busy = 1'b0; // see [R09]
                d.invalid = 1'b1; // see [R09]
            end
            if (host_read_i) begin
                d.res_a = 16'h0; // see [R10]
                d.res_b = 16'h0; // see [R10]
            end
        end else if (q.busy) begin
            if (done_w) begin
                d.res_a = adc_result_a_i; // see [R20]
                d.res_b = adc_result_b_i; // see [R20]
                d.invalid = 1'b0;
                d.busy = 1'b0;
                if (q.seq_on) begin
                    d.seq_chan = chan_n; // see [R13]
                    // burst runs the rest of the sequence from one start, up to the wrap to 0
                    if (q.burst && chan_n != 3'h0) begin // see [R13]
                        d.busy = 1'b1;
                        d.cnt = 16'h0;
                    end
                end
            end else begin
                d.cnt = q.cnt + 16'h0001;
            end
        end else if (start_w) begin
            // a start too soon after reset is taken; the host owns that gap
            d.busy = 1'b1; // see [R12]
            d.cnt = 16'h0;
        end

        // low data pins: device drives only reads, never in serial mode
        d.oe = host_read_i && !inr_w && q.iface != RSMC_IF_SER; // see [R17]
        d.dout = q.res_a[3:0];
        // programming writes only in software parallel or byte mode
        if (host_write_i && !inr_w && !q.hw && q.iface != RSMC_IF_SER) begin // see [R18]
            d.prog_nib = low_data_pins_i; // see [R17]
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.refbuf <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------------
    // outputs, each from a flop
    // ------------------------------------------------------------------------
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;
    assign low_data_pins_o = q.dout;
    assign low_data_pins_oe_o = q.oe;
    assign bandgap_en_o = q.reference_source_strap; // high strap powers the band-gap; see [R02]
    assign ref_buffer_en_o = q.refbuf;
    assign hw_mode_o = q.hw;
    assign range_mode_o = q.range;
    assign interface_mode_o = q.iface;
    assign sequencer_on_o = q.seq_on;
    assign seq_channel_o = q.seq_chan;
    assign conv_busy_o = q.busy;
    assign result_invalid_o = q.invalid;
    assign device_in_reset_o = inr_w;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_busy_hit;
        conv_busy_o ##0 inr_w;
    endsequence

    sequence s_aborted;
        !conv_busy_o ##0 result_invalid_o;
    endsequence

    AST_REF_LATCH: assert property ( // see [R01]
        rel_w |=> bandgap_en_o == $past(reference_source_strap_i))
        else $error("reference strap not caught at release");
    AST_REF_HOLD: assert property (!rel_w |=> $stable(bandgap_en_o)) // see [R01]
        else $error("reference selection changed without reset");
    AST_REF_BUF: assert property (ref_buffer_en_o) // see [R03]
        else $error("reference buffer disabled");
    AST_ABORT: assert property (s_busy_hit |=> s_aborted) // see [R09]
        else $error("conversion not aborted by reset");
    AST_READ_CLEAR: assert property ( // see [R10]
        inr_w && host_read_i |=> q.res_a == 16'h0 && q.res_b == 16'h0)
        else $error("output data not cleared by reset during read");
    AST_MODE_HOLD: assert property ( // see [R07]
        !full_w |=> $stable(range_mode_o) && $stable(interface_mode_o) && $stable(q.burst)
                    || $past(wb_we_i && q.ack))
        else $error("latched mode changed without full reset");
    AST_FULL_LATCH: assert property ( // see [R14]
        full_w |=> range_mode_o == $past(range_mode_strap_i) &&
                   hw_mode_o == ($past(range_mode_strap_i) != `RSMC_RANGE_SW))
        else $error("range strap not latched at full reset");
    AST_FAMILY: assert property ( // see [R15]
        full_w && !interface_family_strap_i |=> interface_mode_o == RSMC_IF_PAR)
        else $error("parallel family not selected");
    AST_SEQ_STEP: assert property ( // see [R13]
        done_w && !inr_w && sequencer_on_o |=>
            seq_channel_o == next_chan($past(seq_channel_o), $past(q.seq_last)))
        else $error("sequencer did not step");
    AST_OE_ROLE: assert property ( // see [R17]
        low_data_pins_oe_o |-> $past(host_read_i) && $past(q.iface) != RSMC_IF_SER)
        else $error("low pins driven outside a read");
    AST_HW_NOWRITE: assert property ( // see [R18]
        hw_mode_o && !full_w |=> $stable(q.prog_nib))
        else $error("programming write taken in hardware mode");

endmodule : rsmc_top

/* File: sim/rsmc_hm.sv */
// rsmc_hm.sv: host model driving reset pin, conversion start, straps and low pins
module rsmc_hm #(
    parameter int RST_TO_CONV = 4 // least wait from reset rise to next start
) (
    input wire logic clk_i,
    output logic rst_n_o,
    output logic conv_o,
    output logic [5:0] strap_o,
    output logic rd_o,
    output logic wr_o,
    output logic [3:0] nib_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wd = 4'h0; // last nibble written
    logic ser; // straps ask for serial
    initial begin
        rst_n_o = 1'b1;
        conv_o = 1'b0;
        strap_o = 6'h00;
        rd_o = 1'b0;
        wr_o = 1'b0;
    end
    // idle pins show the inverse of the last nibble so no stale value passes
    assign ser = strap_o[1] && !strap_o[0];
    assign nib_o = ser ? 4'h0 : (wr_o ? wd : ~wd);
    task automatic set_straps(input logic [5:0] s);
        @(posedge clk_i);
        strap_o <= s;
    endtask : set_straps
    // low time picks the kind; straps held well past the rise
    task automatic pulse(input int n);
        @(posedge clk_i);
        rst_n_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        rst_n_o <= 1'b1;
        repeat (RST_TO_CONV) @(posedge clk_i);
    endtask : pulse
    task automatic start;
        @(posedge clk_i);
        conv_o <= 1'b1;
        @(posedge clk_i);
        conv_o <= 1'b0;
    endtask : start
    task automatic rd(input logic on);
        @(posedge clk_i);
        rd_o <= on;
    endtask : rd
    task automatic wr_nib(input logic [3:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        wd <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask : wr_nib
endmodule : rsmc_hm

/* File: sim/tb_rsmc_top.sv */
// tb_rsmc_top.sv: self-checking bench of the reset, strap and mode block
module tb_rsmc_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic rstn, cv, rd, wr, oe, bg, rbe, hw, sq, busy, inv, inr;
    logic [5:0] st;
    logic [3:0] nib, dout;
    logic [1:0] rng, ifm;
    logic [2:0] ch;
    logic [15:0] ra = 16'h8000, rb = 16'h7fff; // extreme codes, moved per conversion
    logic [3:0] sel = 4'hf; // byte lanes of the current access
    int num_errors = 0, checked = 0;

    always #20 clk_i = ~clk_i; // 25 MHz

    rsmc_top #(.PARTIAL_CYC(2), .FULL_CYC(5), .CONV_CYC(4)) rsmc_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
        .dev_reset_n_i(rstn), .conversion_start_pin_i(cv), .reference_source_strap_i(st[5]),
        .sequencer_enable_strap_i(st[4]), .range_mode_strap_i(st[3:2]),
        .interface_family_strap_i(st[1]), .byte_serial_select_strap_i(st[0]),
        .host_read_i(rd), .host_write_i(wr), .low_data_pins_i(oe ? dout : nib),
        .low_data_pins_o(dout), .low_data_pins_oe_o(oe), .adc_result_a_i(ra),
        .adc_result_b_i(rb), .bandgap_en_o(bg), .ref_buffer_en_o(rbe), .hw_mode_o(hw),
        .range_mode_o(rng), .interface_mode_o(ifm), .sequencer_on_o(sq),
        .seq_channel_o(ch), .conv_busy_o(busy), .result_invalid_o(inv),
        .device_in_reset_o(inr));

    rsmc_hm #(.RST_TO_CONV(4)) rsmc_hm_i (.clk_i(clk_i), .rst_n_o(rstn), .conv_o(cv),
        .strap_o(st), .rd_o(rd), .wr_o(wr), .nib_o(nib));

    task automatic print_verdict;
        if (num_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask : chk

    // one classic cycle: held until ack is seen at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hf);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= s;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            print_verdict();
        end
    endtask : wb

    // bounded wait for the conversion to end
    task automatic conv;
        int n;
        n = 0;
        rsmc_hm_i.start();
        do begin
            @(posedge clk_i);
            n++;
        end while (busy !== 1'b0 && n < 50);
        @(negedge clk_i);
        if (n >= 50) begin
            num_errors++;
            print_verdict();
        end
    endtask : conv

    task automatic t_full_hw;
        rsmc_hm_i.set_straps(6'b111011);
        rsmc_hm_i.pulse(5);
        rsmc_hm_i.set_straps(6'b000000);
        repeat (3) @(negedge clk_i);
        chk(bg, 1);
        chk(rbe, 1);
        chk({hw, rng}, 3'h6);
        chk(ifm, 1);
        chk(sq, 1);
        wb(0, 8'h04, 0);
        chk(q, 32'h3d);
    endtask : t_full_hw

    task automatic t_partial;
        wb(1, 8'h00, 32'h30);
        // lane 0 off: the configuration must not move
        wb(1, 8'h00, 32'h71, 4'he);
        rsmc_hm_i.pulse(2);
        @(negedge clk_i);
        chk(bg, 0);
        chk({hw, rng, ifm}, 5'h19);
        wb(0, 8'h00, 0);
        chk(q, 32'h30);
    endtask : t_partial

    task automatic t_conv;
        int i;
        for (i = 1; i < 5; i++) begin
            // codes move per conversion so a stale load shows
            ra <= 16'h8000 + 16'(i);
            rb <= 16'h7fff - 16'(i);
            conv();
            chk(ch, i % 4);
        end
        wb(0, 8'h0c, 0);
        chk(q, 32'h7ffb8004);
        chk(inv, 0);
        // burst: one start runs the rest of the sequence and wraps to 0
        wb(1, 8'h00, 32'h31);
        conv();
        chk(ch, 0);
    endtask : t_conv

    task automatic t_pins_abort;
        rsmc_hm_i.wr_nib(4'ha);
        wb(0, 8'h08, 0);
        chk(q & 32'hf, 0);
        rsmc_hm_i.rd(1);
        repeat (2) @(negedge clk_i);
        chk({oe, dout}, {1'b1, ra[3:0]});
        rsmc_hm_i.rd(0);
        rsmc_hm_i.start();
        rsmc_hm_i.pulse(1);
        @(negedge clk_i);
        chk({busy, inv}, 2'h1);
        rsmc_hm_i.rd(1);
        rsmc_hm_i.pulse(2);
        rsmc_hm_i.rd(0);
        wb(0, 8'h0c, 0);
        chk(q, 0);
    endtask : t_pins_abort

    task automatic t_sw_serial;
        rsmc_hm_i.pulse(5);
        @(negedge clk_i);
        chk({hw, ifm, sq}, 0);
        wb(0, 8'h00, 0);
        chk(q, 0);
        rsmc_hm_i.wr_nib(4'h5);
        wb(0, 8'h08, 0);
        chk(q & 32'hf, 5);
        rsmc_hm_i.set_straps(6'b000010);
        rsmc_hm_i.pulse(5);
        rsmc_hm_i.rd(1);
        repeat (2) @(negedge clk_i);
        chk({ifm, oe}, 3'h6);
        rsmc_hm_i.rd(0);
        wb(1, 8'h04, 32'hff);
        wb(0, 8'h04, 0);
        chk(q, 32'h60);
        wb(0, 8'h10, 0);
        chk(q, 0);
    endtask : t_sw_serial

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk({rbe, ifm, bg, inr}, 5'h10);
        t_full_hw();
        t_partial();
        t_conv();
        t_pins_abort();
        t_sw_serial();
        print_verdict();
    end
endmodule : tb_rsmc_top
